// [rtl/ebpwm_params.svh]
// constants of the enhanced bridge modulator
`ifndef EBPWM_PARAMS_SVH
`define EBPWM_PARAMS_SVH
// ****************************************
// How it works
// - any reset restores all registers and leaves every output pin undriven
// - all timing counts system clock cycles, so frequency scales with clock
// - bridge mode field: 00 single, 10 half, 01 forward, 11 reverse
// - half bridge uses A and B, full bridge all four, rest released
// - after enable no waveform until a new period starts
// - ten bit time base is timer plus two quarter or prescaler bits
// - half bridge delays each turn-on by dead-band count of four-clock cycles
// - dead-band longer than duty keeps that output inactive whole cycle
// - half bridge drives pwm on A and its complement on B
// - forward holds A active, modulates D, B and C inactive
// - reverse holds C active, modulates B, A and D inactive
// - direction toggle blanks modulated outputs, swaps others, resumes next period
// - unmodulated outputs swap prescale clocks before the period ends
// - no dead-band in either full bridge mode
// - two low mode bits pick polarity of A/C and B/D pairs
// - shutdown sources: low event pin, comparator one, two, software flag
// - shutdown event sets the flag until software or auto restart clears it
// - shutdown forces enabled pins per pair to low, high or undriven
// - clearing the whole mode register releases all four pins
// - pair shutdown field: 00 low, 01 high, 1x undriven
// - source field: bit0 comparator one, bit1 comparator two, bit2 event pin
// - shutdown level held, flag writes ignored, restart at next period
// - auto restart clears flag in hardware when condition goes away
// ****************************************
`define A_MODE 4'h0
`define A_DUTY 4'h1
`define A_PER 4'h2
`define A_TCTL 4'h3
`define A_TMR 4'h4
`define A_DBAND 4'h5
`define A_SHDN 4'h6
`define A_PDIR 4'h7
`define A_STAT 4'h8
`define RST_PDIR 4'hF
`define PWM_ON 2'b11
`define TCY_CLKS 9'h004
`define PS_1 7'h01
`define PS_4 7'h04
`define PS_16 7'h10
`endif

// [rtl/ebpwm_pkg.sv]
// types of the enhanced bridge modulator
package ebpwm_pkg;
    `include "ebpwm_params.svh"

    typedef enum logic [1:0] {SINGLE, HALF, FWD, REV} bmode_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe;
    } pins_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] duty;
        logic [7:0] per;
        logic [2:0] tctl;
        logic [7:0] tmr;
        logic [5:0] psc;
        logic [7:0] dband;
        logic [7:0] shdn;
        logic [3:0] pdir;
        logic tflag;
        logic [9:0] duty_lat;
        logic pwm;
        logic armed;
        logic dir;
        logic dir_pend;
        logic [8:0] db_cnt;
        logic shut;
        logic [7:0] rdata;
        pins_t pins;
    } state_t;
endpackage : ebpwm_pkg

// [rtl/enhanced_bridge_pwm.sv]
// enhanced bridge pwm output stage with dead-band and auto-shutdown
`timescale 1ns/1ps
`include "ebpwm_params.svh"

module enhanced_bridge_pwm (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire ebpwm_pkg::bus_req_t req,
    output logic [7:0] rdata,
    input wire logic comparator_one,
    input wire logic comparator_two,
    input wire logic shutdown_pin_n,
    output ebpwm_pkg::pins_t pins
);
    import ebpwm_pkg::*;

    state_t q;
    state_t d;
    bmode_t bm;
    logic pwm_en;
    logic [6:0] presc;
    logic [5:0] limit;
    logic [1:0] lowb;
    logic [9:0] tb;
    logic tick_end;
    logic pstart;
    logic swap_now;
    logic sd_req;
    logic forced;
    logic [3:0] act;
    logic [3:0] used;
    logic [3:0] drv;
    logic [3:0] pol;
    logic [9:0] duty_new;

    assign rdata = q.rdata;
    assign pins = q.pins;

    // ****************************************
    // mode decode
    // ****************************************
    always_comb begin
        unique case (q.mode[7:6])
            2'b00: bm = SINGLE;
            2'b10: bm = HALF;
            2'b01: bm = FWD;
            2'b11: bm = REV;
        endcase
    end

    assign pwm_en = (q.mode[3:2] == `PWM_ON);

    // ****************************************
    // time base
    // ****************************************
    always_comb begin
        unique case (q.tctl[1:0])
            2'b00: presc = `PS_1;
            2'b01: presc = `PS_4;
            default: presc = `PS_16;
        endcase
    end

    // quarter clock or prescaler supplies the two low bits
    assign limit = 6'(presc * 7'h04 - 7'h01);
    always_comb begin
        unique case (q.tctl[1:0])
            2'b00: lowb = q.psc[1:0];
            2'b01: lowb = q.psc[3:2];
            default: lowb = q.psc[5:4];
        endcase
    end
    assign tb = {q.tmr, lowb};
    assign tick_end = q.tctl[2] && (q.psc == limit);
    assign pstart = tick_end && (q.tmr == q.per);
    // unmodulated pins lead the period end by prescale clocks
    assign swap_now = q.tctl[2] && (q.tmr == q.per)
        && (7'(q.psc) == 7'(limit) + 7'h01 - presc);
    assign duty_new = {q.duty, q.mode[5:4]};

    // ****************************************
    // shutdown request
    // ****************************************
    assign sd_req = (q.shdn[4] && comparator_one)
        || (q.shdn[5] && comparator_two)
        || (q.shdn[6] && !shutdown_pin_n);
    assign forced = sd_req || q.shdn[7] || q.shut;

    // ****************************************
    // output steering
    // ****************************************
    always_comb begin
        act = 4'h0;
        used = 4'h0;
        unique case (bm)
            SINGLE: begin
                used = 4'b0001;
                act[0] = q.pwm;
            end
            HALF: begin
                used = 4'b0011;
                act[0] = q.pwm && (q.db_cnt == 9'h000);
                act[1] = !q.pwm && (q.db_cnt == 9'h000);
            end
            FWD, REV: begin
                used = 4'b1111;
                if (!q.dir) begin
                    act[0] = 1'b1;
                    act[3] = q.pwm && !q.dir_pend;
                end else begin
                    act[2] = 1'b1;
                    act[1] = q.pwm && !q.dir_pend;
                end
            end
        endcase
        if (!q.armed) begin
            act = 4'h0;
        end
    end

    assign pol = {q.mode[0], q.mode[1], q.mode[0], q.mode[1]};
    assign drv = used & ~q.pdir & {4{pwm_en}};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.rdata = 8'h00;
        // auto restart before writes so a software set survives
        if (q.dband[7] && !sd_req && q.shdn[7]) begin
            d.shdn[7] = 1'b0;
        end
        if (req.wr) begin
            unique case (req.addr)
                `A_MODE: d.mode = req.wdata;
                `A_DUTY: d.duty = req.wdata;
                `A_PER: d.per = req.wdata;
                `A_TCTL: d.tctl = req.wdata[2:0];
                `A_DBAND: d.dband = req.wdata;
                `A_SHDN: begin
                    d.shdn[6:0] = req.wdata[6:0];
                    if (!sd_req) begin
                        d.shdn[7] = req.wdata[7];
                    end
                end
                `A_PDIR: d.pdir = req.wdata[3:0];
                `A_STAT: begin
                    if (req.wdata[0]) begin
                        d.tflag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (req.rd) begin
            unique case (req.addr)
                `A_MODE: d.rdata = q.mode;
                `A_DUTY: d.rdata = q.duty;
                `A_PER: d.rdata = q.per;
                `A_TCTL: d.rdata = {5'h00, q.tctl};
                `A_TMR: d.rdata = q.tmr;
                `A_DBAND: d.rdata = q.dband;
                `A_SHDN: d.rdata = q.shdn;
                `A_PDIR: d.rdata = {4'h0, q.pdir};
                `A_STAT: d.rdata = {6'h00, q.shut, q.tflag};
                default: d.rdata = 8'h00;
            endcase
        end
        // timer and prescaler
        if (q.tctl[2]) begin
            d.psc = tick_end ? 6'h00 : q.psc + 6'h01;
            if (tick_end) begin
                d.tmr = (q.tmr == q.per) ? 8'h00 : q.tmr + 8'h01;
            end
        end
        if (req.wr && req.addr == `A_TMR) begin
            d.tmr = req.wdata;
        end
        // raw waveform
        if (pstart) begin
            d.tflag = 1'b1;
            d.duty_lat = duty_new;
            d.pwm = (duty_new != 10'h000);
            d.armed = pwm_en;
        end else if (tb == q.duty_lat - 10'h001) begin
            // pwm falls one clock into count duty minus one, so width is exactly duty only at prescale 1
            d.pwm = 1'b0;
        end
        if (!pwm_en) begin
            d.armed = 1'b0;
        end
        // dead-band counter restarts on each edge of the raw waveform
        if (d.pwm != q.pwm) begin
            d.db_cnt = 9'(q.dband[6:0]) * `TCY_CLKS;
        end else if (q.db_cnt != 9'h000) begin
            d.db_cnt = q.db_cnt - 9'h001;
        end
        // direction sequencing
        if (!q.mode[6]) begin
            d.dir = q.mode[7];
            d.dir_pend = 1'b0;
        end else begin
            if (q.mode[7] != q.dir) begin
                d.dir_pend = 1'b1;
                if (swap_now) begin
                    d.dir = q.mode[7];
                end
            end
            if (pstart && (swap_now || q.mode[7] == q.dir)) begin
                d.dir_pend = 1'b0;
            end
        end
        // shutdown flag and latched state
        if (sd_req) begin
            d.shdn[7] = 1'b1;
        end
        if (sd_req || q.shdn[7]) begin
            d.shut = 1'b1;
        end else if (pstart) begin
            d.shut = 1'b0;
        end
        // pins
        if (forced) begin
            d.pins.lvl = {q.shdn[0], q.shdn[2], q.shdn[0], q.shdn[2]};
            d.pins.oe = drv & ~{q.shdn[1], q.shdn[3], q.shdn[1], q.shdn[3]};
        end else begin
            d.pins.lvl = act ^ pol;
            d.pins.oe = drv;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.pdir <= `RST_PDIR;
        end else if (ce) begin
            q <= d;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    reset_pins_a: assert property (
        @(posedge mclk) disable iff (rst)
        $past(rst) |-> (q.pins.oe == 4'h0) && (q.mode == 8'h00))
        else $error("pins driven after reset");

    clear_release_a: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && q.mode == 8'h00 && !(req.wr && req.addr == `A_MODE))
        |=> (q.pins.oe == 4'h0))
        else $error("pins held with mode cleared");

    timer_wrap_a: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && pstart && !(req.wr && req.addr == `A_TMR))
        |=> (q.tmr == 8'h00) && q.tflag && (q.psc == 6'h00))
        else $error("timer did not wrap at period");

    deadband_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        (bm == HALF && q.db_cnt != 9'h000) |-> (act[1:0] == 2'b00))
        else $error("half bridge output active in dead-band");

    half_comp_a: assert property (
        @(posedge mclk) disable iff (rst)
        (bm == HALF && q.armed && q.db_cnt == 9'h000)
        |-> (act[0] == q.pwm) && (act[1] == !q.pwm))
        else $error("half bridge outputs not complementary");

    forward_map_a: assert property (
        @(posedge mclk) disable iff (rst)
        (q.mode[6] && !q.dir && q.armed)
        |-> act[0] && !act[1] && !act[2] && (act[3] == (q.pwm && !q.dir_pend)))
        else $error("forward mapping wrong");

    reverse_map_a: assert property (
        @(posedge mclk) disable iff (rst)
        (q.mode[6] && q.dir && q.armed)
        |-> act[2] && !act[0] && !act[3] && (act[1] == (q.pwm && !q.dir_pend)))
        else $error("reverse mapping wrong");

    no_early_a: assert property (
        @(posedge mclk) disable iff (rst)
        !q.armed |-> (act == 4'h0))
        else $error("waveform before period start");

    flag_set_a: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && sd_req) |=> q.shdn[7] && q.shut)
        else $error("shutdown flag not set");

    sd_drive_a: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && sd_req && drv[0] && q.shdn[3:2] == 2'b01)
        |=> q.pins.oe[0] && q.pins.lvl[0])
        else $error("pair A/C not forced high");

    sd_tri_a: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && sd_req && q.shdn[1]) |=> !q.pins.oe[1] && !q.pins.oe[3])
        else $error("pair B/D not released in shutdown");

    auto_clear_a: assert property (
        @(posedge mclk) disable iff (rst)
        (ce && q.dband[7] && q.shdn[7] && !sd_req
            && !(req.wr && req.addr == `A_SHDN)) |=> !q.shdn[7])
        else $error("auto restart did not clear flag");
endmodule : enhanced_bridge_pwm

// [verif/bridge_switch_model.sv]
// model of the external bridge switch drivers on the four pwm pins
`timescale 1ns/1ps
module bridge_switch_model (
    input wire ebpwm_pkg::pins_t pins,
    input wire logic fault_cmd,
    output logic [3:0] wire_lvl,
    output logic shutdown_pin_n
);
    import ebpwm_pkg::*;
    // ****************************************
    // pin wires with pull-downs
    // ****************************************
    // undriven pins fall to the pull-down level, switches stay off
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wire_lvl[i] = pins.oe[i] ? pins.lvl[i] : 1'b0;
        end
    end
    // fault line with pull-up, pulled low on a stage fault
    assign shutdown_pin_n = fault_cmd ? 1'b0 : 1'b1;
endmodule : bridge_switch_model

// [verif/tb_enhanced_bridge_pwm.sv]
// self-checking bench of the enhanced bridge pwm
`timescale 1ns/1ps
`include "ebpwm_params.svh"
module tb_enhanced_bridge_pwm;
    import ebpwm_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    bus_req_t req = '0;
    logic [7:0] rdata;
    logic comparator_one = 1'b0;
    logic comparator_two = 1'b0;
    logic fault_cmd = 1'b0;
    logic shutdown_pin_n;
    pins_t pins;
    logic [3:0] wire_lvl;
    logic [7:0] rd_q;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    int cnt[4];

    always #5 mclk = ~mclk;

    enhanced_bridge_pwm uut (.mclk(mclk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
        .comparator_one(comparator_one), .comparator_two(comparator_two),
        .shutdown_pin_n(shutdown_pin_n), .pins(pins));
    bridge_switch_model drv (.pins(pins), .fault_cmd(fault_cmd), .wire_lvl(wire_lvl),
        .shutdown_pin_n(shutdown_pin_n));

    // ****************************************
    // helpers
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge mclk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        #1 rd_q = rdata;
    endtask : rd

    task automatic meas();
        cnt = '{0, 0, 0, 0};
        repeat (32) begin
            @(posedge mclk);
            #1;
            for (int i = 0; i < 4; i++) cnt[i] += (wire_lvl[i] === 1'b1) ? 1 : 0;
        end
    endtask : meas

    // drivers off, program, wait for the period flag, then drivers on
    task automatic setup(input logic [7:0] md, input logic [7:0] du, input logic [7:0] db);
        int n;
        wr(`A_PDIR, 8'h0F);
        wr(`A_PER, 8'h03);
        wr(`A_MODE, md);
        wr(`A_DUTY, du);
        wr(`A_DBAND, db);
        wr(`A_STAT, 8'h01);
        wr(`A_TCTL, 8'h04);
        n = 0;
        rd_q = 8'h00;
        while (rd_q[0] !== 1'b1 && n < 50) begin
            rd(`A_STAT);
            n++;
        end
        chk({15'h0000, rd_q[0]}, 16'h0001);
        wr(`A_PDIR, 8'h00);
        repeat (20) @(posedge mclk);
    endtask : setup

    task automatic run_mode(input logic [7:0] md, du, db, input logic [3:0] eoe,
            input logic [15:0] ea, eb, ec, ed);
        setup(md, du, db);
        chk({12'h000, pins.oe}, {12'h000, eoe});
        meas();
        chk(16'(cnt[0]), ea);
        chk(16'(cnt[1]), eb);
        chk(16'(cnt[2]), ec);
        chk(16'(cnt[3]), ed);
        $display("test mode %h duty %h dband %h done", md, du, db);
    endtask : run_mode

    // fault from one source: A/C high, B/D undriven
    task automatic shut(input int s);
        logic [7:0] cfg;
        cfg = 8'h06 | (8'h10 << s);
        wr(`A_DBAND, (s == 2) ? 8'h80 : 8'h00);
        wr(`A_SHDN, cfg);
        @(posedge mclk);
        comparator_one <= (s == 0);
        comparator_two <= (s == 1);
        fault_cmd <= (s == 2);
        repeat (3) @(posedge mclk);
        #1;
        chk({12'h000, pins.oe}, 16'h0001);
        chk({12'h000, wire_lvl}, 16'h0001);
        wr(`A_SHDN, cfg);
        rd(`A_SHDN);
        chk({8'h00, rd_q}, {8'h00, cfg | 8'h80});
        @(posedge mclk);
        comparator_one <= 1'b0;
        comparator_two <= 1'b0;
        fault_cmd <= 1'b0;
        if (s != 2) wr(`A_SHDN, cfg);
        repeat (40) @(posedge mclk);
        rd(`A_SHDN);
        chk({8'h00, rd_q}, {8'h00, cfg});
        chk({12'h000, pins.oe}, 16'h0003);
        $display("test shutdown source %0d done", s);
    endtask : shut

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        chk({12'h000, pins.oe}, 16'h0000);
        for (int a = 0; a < 10; a++) begin
            rd(4'(a));
            chk({8'h00, rd_q}, (a == 7) ? 16'h000F : 16'h0000);
        end
        $display("test reset done");
        run_mode(8'h0C, 8'h02, 8'h00, 4'h1, 16, 0, 0, 0);
        run_mode(8'h0F, 8'h01, 8'h00, 4'h1, 24, 0, 0, 0);
        run_mode(8'h8C, 8'h02, 8'h00, 4'h3, 16, 16, 0, 0);
        for (int s = 0; s < 3; s++) shut(s);
        wr(`A_SHDN, 8'h00);
        run_mode(8'h8C, 8'h02, 8'h01, 4'h3, 8, 8, 0, 0);
        run_mode(8'h8C, 8'h02, 8'h03, 4'h3, 0, 0, 0, 0);
        run_mode(8'h4C, 8'h02, 8'h01, 4'hF, 32, 0, 0, 16);
        run_mode(8'hCC, 8'h02, 8'h01, 4'hF, 0, 16, 32, 0);
        wr(`A_MODE, 8'h00);
        repeat (3) @(posedge mclk);
        #1;
        chk({12'h000, pins.oe}, 16'h0000);
        $display("test release done");
        close_out();
    end
endmodule : tb_enhanced_bridge_pwm
